// >>> pkg/acc_pkg.sv
// Constants, register offsets and field positions of the eight-bit accumulator.
package acc_pkg;
  localparam int DATA_W = 8;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 32;
  // Register byte offsets on the bus.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OPERAND_OFS = 8'h04;
  localparam logic [7:0] LOAD_DATA_OFS = 8'h08;
  localparam logic [7:0] COMMAND_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // Control register fields.
  localparam int CTRL_ADD_SEL_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_CARRY_BIT = 2;
  localparam int CTRL_CARRY_PIN_BIT = 3;
  localparam int CTRL_W = 4;
  // Command register fields, write-only pulses.
  localparam int CMD_LOAD_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  // Status register fields.
  localparam int STAT_CARRY_BIT = 8;
  localparam int STAT_OVF_BIT = 9;
  // Values after reset.
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;
  // Register index codes used by the decoder.
  typedef enum logic [2:0] {
    IDX_CTRL = 3'h0,
    IDX_OPERAND = 3'h1,
    IDX_LOAD = 3'h2,
    IDX_CMD = 3'h3,
    IDX_STATUS = 3'h4,
    IDX_NONE = 3'h7
  } reg_idx_t;
endpackage

// >>> verif/eight_bit_accumulator_bench.sv
// Self-checking bench of the eight-bit accumulator and its register slave.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_accumulator_bench;
  import acc_pkg::*;
  logic clk = 0, rst = 1, global_set_reset_line = 0, req = 0, hw = 0, add = 1;
  logic [1:0] ht = 0;
  logic [31:0] ha = 0, hd = 0, rd, hr;
  logic [7:0] q;
  logic ci, co, ov, rdy, uo, hresp;
  int miscompares = 0, n_compared = 0;
  initial forever #12.5 clk = ~clk;
  eight_bit_accumulator u_eight_bit_accumulator (.CLK_SYS(clk), .RST(rst),
    .GLOBAL_SET_RESET_LINE(global_set_reset_line), .HSEL(1'b1), .HADDR(ha), .HTRANS(ht), .HWRITE(hw),
    .HSIZE(3'h2), .HREADY(rdy), .HWDATA(hd), .HRDATA(hr), .HREADYOUT(rdy), .HRESP(hresp),
    .CARRY_INPUT(ci), .ACC_Q(q), .CARRY_OUTPUT(co), .SIGNED_OVERFLOW(ov));
  user_logic_model u_user_logic_model (.clk(clk), .carry_req(req), .carry_output(co),
    .add_sel(add), .carry_input(ci), .unsigned_ovf(uo));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Ready and read data are taken at the rising edge, before the slave's flops move.
  task automatic wt();
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = hr;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    ha <= {24'h0, a};
    ht <= 2'h2;
    hw <= w;
    wt();
    ht <= 2'h0;
    hd <= d;
    wt();
  endtask
  task automatic ld(input logic [7:0] v);
    bus(LOAD_DATA_OFS, 1, {24'h0, v});
    bus(COMMAND_OFS, 1, 32'h1);
    #1 chk("acc_q load", q, v);
  endtask
  // Enable stays on for n idle edges plus the two edges of the closing write.
  task automatic run(input logic [3:0] c, input int n);
    add <= c[0];
    bus(CTRL_OFS, 1, {28'h0, c});
    repeat (n) @(posedge clk);
    bus(CTRL_OFS, 1, {28'h0, c & 4'hd});
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(CTRL_OFS, 0, 0);
    chk("ctrl reset", rd, 32'h1);
    bus(STATUS_OFS, 0, 0);
    chk("status reset", rd, 32'h0);
    bus(8'h20, 1, 32'hff);
    bus(8'h20, 0, 0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", hresp, 1'b0);
  endtask
  task automatic t_add();
    ld(8'hf0);
    bus(OPERAND_OFS, 1, 32'h20);
    #1 chk("carry add", co, 1'b1);
    chk("ovf add", ov, 1'b0);
    chk("unsigned ovf", uo, 1'b0);
    bus(STATUS_OFS, 0, 0);
    chk("status", rd, 32'h1f0);
    run(4'h7, 1);
    chk("acc_q add", q, 8'h53);
    repeat (4) @(posedge clk);
    #1 chk("acc_q hold", q, 8'h53);
  endtask
  task automatic t_sub();
    ld(8'h80);
    bus(OPERAND_OFS, 1, 32'h1);
    bus(CTRL_OFS, 1, 32'h0);
    #1 chk("carry sub", co, 1'b1);
    chk("ovf sub", ov, 1'b1);
    ld(8'h00);
    chk("borrow sub", co, 1'b0);
    chk("ovf none", ov, 1'b0);
    req <= 1;
    run(4'ha, 1);
    chk("acc_q sub", q, 8'hfa);
    req <= 0;
  endtask
  task automatic t_clear();
    bus(LOAD_DATA_OFS, 1, 32'h55);
    bus(COMMAND_OFS, 1, 32'h3);
    #1 chk("clear over load", q, 8'h00);
    ld(8'h55);
    rst <= 1;
    @(posedge clk);
    #1 chk("acc_q rst", q, 8'h00);
    rst <= 0;
    @(posedge clk);
    ld(8'h55);
    @(posedge clk);
    global_set_reset_line <= 1;
    #1 chk("acc_q gsr", q, 8'h00);
    @(posedge clk);
    global_set_reset_line <= 0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset();
    t_add();
    t_sub();
    t_clear();
    close_out();
  end
  initial begin
    #50000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire

// >>> verif/user_logic_model.sv
// Model of the user logic that feeds the cascade carry of the accumulator.
`timescale 1ns/1ps
`default_nettype none
module user_logic_model (
  // Clock and bench request.
  input wire logic clk,
  input wire logic carry_req,
  // Accumulator side.
  input wire logic carry_output,
  input wire logic add_sel,
  output logic carry_input,
  output logic unsigned_ovf
);
  // The carry leaves a flop, as from a cascaded stage on the same clock.
  always_ff @(posedge clk) begin
    carry_input <= carry_req;
  end
  // Unsigned overflow is the carry XOR add_sel; signed overflow is never read here.
  assign unsigned_ovf = carry_output ^ add_sel;
endmodule
`default_nettype wire

// >>> verilog/eight_bit_accumulator.sv
// Eight-bit loadable cascadable accumulator with an AHB-Lite register slave.
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_accumulator
  import acc_pkg::*;
(
  // Clock and resets.
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic GLOBAL_SET_RESET_LINE,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [acc_pkg::ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [acc_pkg::BUS_W-1:0] HWDATA,
  output logic [acc_pkg::BUS_W-1:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Cascade and result.
  input wire logic CARRY_INPUT,
  output logic [acc_pkg::DATA_W-1:0] ACC_Q,
  output logic CARRY_OUTPUT,
  output logic SIGNED_OVERFLOW
);
  import acc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic reg_idx_t decode(input logic [ADDR_W-1:0] a);
    reg_idx_t r;
    r = IDX_NONE;
    if (a[ADDR_W-1:8] == '0 && a[1:0] == 2'b00) begin
      unique case (a[7:0])
        CTRL_OFS: r = IDX_CTRL;
        OPERAND_OFS: r = IDX_OPERAND;
        LOAD_DATA_OFS: r = IDX_LOAD;
        COMMAND_OFS: r = IDX_CMD;
        STATUS_OFS: r = IDX_STATUS;
        default: r = IDX_NONE;
      endcase
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [CTRL_W-1:0] ctrl_r;
  logic [DATA_W-1:0] operand_r;
  logic [DATA_W-1:0] load_data_r;
  logic [DATA_W-1:0] acc_r;
  logic wr_pend_r;
  reg_idx_t wr_idx_r;
  logic rd_wait_r;
  reg_idx_t rd_idx_r;
  logic [BUS_W-1:0] hrdata_r;
  logic take;
  logic wr_cmd;
  logic load_now;
  logic clear_now;
  logic add_sel;
  logic enable;
  logic carry_in;
  logic [DATA_W:0] sum_u;
  logic [DATA_W:0] diff_u;
  logic [DATA_W+1:0] res_s;
  logic [DATA_W-1:0] result;

  // Bus phases: an address phase is taken only when the bus is ready.
  assign take = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = !rd_wait_r;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_r;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= IDX_NONE;
      rd_wait_r <= 1'b0;
      rd_idx_r <= IDX_NONE;
    end else begin
      wr_pend_r <= take && HWRITE;
      rd_wait_r <= take && !HWRITE;
      if (take) begin
        wr_idx_r <= decode(HADDR);
        rd_idx_r <= decode(HADDR);
      end
    end
  end

  // Reads hold one wait state so that data reflect writes just committed.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hrdata_r <= BUS_ZERO;
    end else if (rd_wait_r) begin
      hrdata_r <= BUS_ZERO;
      unique case (rd_idx_r)
        IDX_CTRL: hrdata_r[CTRL_W-1:0] <= ctrl_r;
        IDX_OPERAND: hrdata_r[DATA_W-1:0] <= operand_r;
        IDX_LOAD: hrdata_r[DATA_W-1:0] <= load_data_r;
        IDX_STATUS: begin
          hrdata_r[DATA_W-1:0] <= acc_r;
          hrdata_r[STAT_CARRY_BIT] <= CARRY_OUTPUT;
          hrdata_r[STAT_OVF_BIT] <= SIGNED_OVERFLOW;
        end
        default: hrdata_r <= BUS_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_r <= CTRL_RST;
      operand_r <= DATA_RST;
      load_data_r <= DATA_RST;
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        IDX_CTRL: ctrl_r <= HWDATA[CTRL_W-1:0];
        IDX_OPERAND: operand_r <= HWDATA[DATA_W-1:0];
        IDX_LOAD: load_data_r <= HWDATA[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign wr_cmd = wr_pend_r && (wr_idx_r == IDX_CMD);
  assign load_now = wr_cmd && HWDATA[CMD_LOAD_BIT];
  assign clear_now = RST || (wr_cmd && HWDATA[CMD_CLEAR_BIT]);
  assign add_sel = ctrl_r[CTRL_ADD_SEL_BIT];
  assign enable = ctrl_r[CTRL_ENABLE_BIT];
  assign carry_in = ctrl_r[CTRL_CARRY_PIN_BIT] ? CARRY_INPUT : ctrl_r[CTRL_CARRY_BIT];

  // Carry enters at bit 0 of an eight-bit operand.
  assign sum_u = {1'b0, acc_r} + {1'b0, operand_r} + {{DATA_W{1'b0}}, carry_in};
  assign diff_u = {1'b0, acc_r} - {1'b0, operand_r} - {{DATA_W{1'b0}}, carry_in};
  // Sign-extended result two bits wider than the register exposes signed overflow.
  assign res_s = add_sel ?
    {{2{acc_r[DATA_W-1]}}, acc_r} + {{2{operand_r[DATA_W-1]}}, operand_r}
      + {{(DATA_W+1){1'b0}}, carry_in} :
    {{2{acc_r[DATA_W-1]}}, acc_r} - {{2{operand_r[DATA_W-1]}}, operand_r}
      - {{(DATA_W+1){1'b0}}, carry_in};
  assign result = add_sel ? sum_u[DATA_W-1:0] : diff_u[DATA_W-1:0];
  assign CARRY_OUTPUT = add_sel ? sum_u[DATA_W] : !diff_u[DATA_W];
  assign SIGNED_OVERFLOW = (res_s[DATA_W+1:DATA_W-1] != 3'b000)
    && (res_s[DATA_W+1:DATA_W-1] != 3'b111);
  assign ACC_Q = acc_r;

  always_ff @(posedge CLK_SYS or posedge GLOBAL_SET_RESET_LINE) begin
    if (GLOBAL_SET_RESET_LINE) begin
      acc_r <= DATA_RST;
    end else if (clear_now) begin
      acc_r <= DATA_RST;
    end else if (load_now) begin
      acc_r <= load_data_r;
    end else if (enable) begin
      acc_r <= result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (GLOBAL_SET_RESET_LINE);

  property p_clear;
    clear_now |=> (ACC_Q == DATA_RST);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero register");

  property p_load;
    !clear_now && load_now |=> (ACC_Q == $past(load_data_r));
  endproperty
  a_load: assert property (p_load) else $error("load word not taken");

  property p_add;
    !clear_now && !load_now && enable && add_sel
      |=> (ACC_Q == DATA_W'($past(acc_r) + $past(operand_r) + $past(carry_in)));
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");

  property p_sub;
    !clear_now && !load_now && enable && !add_sel
      |=> (ACC_Q == DATA_W'($past(acc_r) - $past(operand_r) - $past(carry_in)));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");

  property p_hold;
    !clear_now && !load_now && !enable |=> $stable(ACC_Q);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved while disabled");

  property p_carry_add;
    add_sel |-> (CARRY_OUTPUT == ((int'(acc_r) + int'(operand_r) + int'(carry_in)) > 255));
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("carry wrong in add");

  property p_borrow;
    !add_sel |-> (CARRY_OUTPUT == ((int'(acc_r) - int'(operand_r) - int'(carry_in)) >= 0));
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow wrong in subtract");

  // Checked only once reset has given the registers known values.
  property p_ovf;
    !RST |-> (SIGNED_OVERFLOW == (add_sel ?
      (((int'($signed(acc_r)) + int'($signed(operand_r)) + int'(carry_in)) > 127)
        || ((int'($signed(acc_r)) + int'($signed(operand_r)) + int'(carry_in)) < -128)) :
      (((int'($signed(acc_r)) - int'($signed(operand_r)) - int'(carry_in)) > 127)
        || ((int'($signed(acc_r)) - int'($signed(operand_r)) - int'(carry_in)) < -128))));
  endproperty
  a_ovf: assert property (p_ovf) else $error("signed overflow wrong");

  property p_read_wait;
    disable iff (RST)
    take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state missing");
endmodule
`default_nettype wire
